/* sim/interrupt_vector_relocation_tb.sv */
// Self-checking bench: Avalon-MM register tasks and placement sequences.
// Assumes ivr_pkg, ivr_top and ivr_core_model are compiled first.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module interrupt_vector_relocation_tb;
   import ivr_pkg::*;
   logic              core_clk_i, rst_i, avs_read, avs_write, avs_waitrequest;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0]       avs_writedata, avs_readdata;
   logic              fz, al, bl, gie, allow, blk, ext0, ext1;
   logic [1:0]        sz;
   logic [PC_W-1:0]   pc_t, pc, rst_a, vec_a;
   logic [4:0]        irq_t, irq;
   logic [7:0]        cnt, cnt0;
   int                n_errors, checks_done;

   ivr_top dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .boot_reset_fuse_i(fz), .boot_size_fuses_i(sz),
      .app_side_boot_lock_i(al), .boot_side_boot_lock_i(bl), .pc_word_i(pc),
      .global_irq_enable_i(gie), .irq_num_i(irq), .irq_allow_o(allow), .irq_block_o(blk),
      .reset_addr_o(rst_a), .vector_addr_o(vec_a), .ext_irq_zero_enable_o(ext0),
      .ext_irq_one_enable_o(ext1));
   ivr_core_model core_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .pc_target_i(pc_t),
      .irq_target_i(irq_t), .irq_allow_i(allow), .pc_word_o(pc), .global_irq_enable_o(gie),
      .irq_num_o(irq), .taken_cnt_o(cnt));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk_i);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= ~w;
      avs_writedata <= {24'h000000, d};
      @(posedge core_clk_i);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge core_clk_i);
         n++;
      end
      if (avs_waitrequest !== 1'b0) begin
         n_errors++;
         end_of_test();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      `CHK(nm, exp, q)
   endtask : rd

   task automatic look(input int n);
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask : look

   task automatic apply(input logic f, input logic [1:0] s, input logic a, input logic b);
      @(posedge core_clk_i);
      fz    <= f;
      sz    <= s;
      al    <= a;
      bl    <= b;
      rst_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      rst_i <= 1'b0;
   endtask : apply

   task automatic relocate;
      wr(CTRL_OFS, 8'h01);
      wr(CTRL_OFS, 8'h02);
   endtask : relocate

   task automatic vec(input logic [4:0] n, input logic [PC_W-1:0] exp);
      @(posedge core_clk_i);
      irq_t <= n;
      look(3);
      `CHK("vector_addr", exp, vec_a)
   endtask : vec

   task automatic gate(input logic [PC_W-1:0] p, input logic exp);
      @(posedge core_clk_i);
      pc_t <= p;
      look(3);
      `CHK("lock_gate", exp, blk)
   endtask : gate

   function automatic logic [PC_W-1:0] base_of(input logic [1:0] s);
      case (s)
         2'h0:    return 12'hc00;
         2'h1:    return 12'he00;
         2'h2:    return 12'hf00;
         default: return 12'hf80;
      endcase
   endfunction : base_of

   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      end_of_test();
   end

   initial begin
      {rst_i, avs_read, avs_write, fz, al, bl} = 6'b100111;
      avs_address   = 4'h0;
      avs_writedata = 32'h0;
      sz            = 2'h0;
      pc_t          = 12'h000;
      irq_t         = 5'h01;
      apply(1'b1, 2'h0, 1'b1, 1'b1);
      rd("ctrl_reset", CTRL_OFS, 32'h0);
      wr(CTRL_OFS, 8'h3c);
      rd("ctrl_unused", CTRL_OFS, 32'h0);
      wr(CTRL_OFS, 8'hc0);
      rd("ctrl_ext", CTRL_OFS, 32'hc0);
      `CHK("ext_en", 2'b11, {ext1, ext0})
      rd("unmapped", 4'h8, 32'h0);
      wr(CTRL_OFS, 8'h02);
      rd("sel_no_unlock", CTRL_OFS, 32'h0);
      // Unlock left to expire
      wr(CTRL_OFS, 8'h01);
      look(0);
      `CHK("blk_open", 1'b1, blk)
      `CHK("allow_open", 1'b0, allow)
      cnt0 = cnt;
      look(3);
      `CHK("blk_late", 1'b1, blk)
      `CHK("no_dispatch", cnt0, cnt)
      look(1);
      `CHK("blk_free", 1'b0, blk)
      `CHK("allow_free", 1'b1, allow)
      rd("unlock_expired", CTRL_OFS, 32'h0);
      wr(CTRL_OFS, 8'h01);
      repeat (2) @(posedge core_clk_i);
      wr(CTRL_OFS, 8'h02);
      rd("sel_late", CTRL_OFS, 32'h0);
      wr(CTRL_OFS, 8'h01);
      rd("unlock_set", CTRL_OFS, 32'h1);
      look(6);
      // Select write taken on the last open cycle
      wr(CTRL_OFS, 8'h01);
      @(posedge core_clk_i);
      wr(CTRL_OFS, 8'h02);
      look(0);
      `CHK("blk_hold", 1'b1, blk)
      look(2);
      `CHK("blk_done", 1'b0, blk)
      rd("sel_set", CTRL_OFS, 32'h2);
      rd("status_sel", STAT_OFS, 32'h1);
      `CHK("rst_app", 12'h000, rst_a)
      vec(5'd1, 12'hc01);
      vec(5'd18, 12'hc12);
      for (int s = 0; s < 4; s++) begin
         apply(1'b0, 2'(s), 1'b1, 1'b1);
         look(1);
         `CHK("rst_boot", base_of(2'(s)), rst_a)
         vec(5'd1, 12'h001);
         vec(5'd18, 12'h012);
         relocate();
         vec(5'd1, base_of(2'(s)) + 12'h001);
      end
      apply(1'b1, 2'h0, 1'b0, 1'b1);
      relocate();
      gate(12'h100, 1'b1);
      gate(12'hc10, 1'b0);
      apply(1'b1, 2'h0, 1'b1, 1'b0);
      gate(12'hc10, 1'b1);
      gate(12'h100, 1'b0);
      end_of_test();
   end
endmodule : interrupt_vector_relocation_tb

/* sim/ivr_core_model.sv */
// Core-side model: program word address, I-flag and pending vector number.
// Assumes the bench steers it through target inputs; one clock, sync reset.
`timescale 1ns/100ps
module ivr_core_model (
   // Clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_i,
   // Steering from the bench
   input  wire logic [ivr_pkg::PC_W-1:0] pc_target_i,
   input  wire logic [4:0]               irq_target_i,
   // Block side
   input  wire logic                     irq_allow_i,
   output logic      [ivr_pkg::PC_W-1:0] pc_word_o,
   output logic                          global_irq_enable_o,
   output logic      [4:0]               irq_num_o,
   output logic      [7:0]               taken_cnt_o
);
   import ivr_pkg::*;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pc_word_o           <= APP_RESET_ADDR;
         global_irq_enable_o <= 1'b0;
         irq_num_o           <= 5'h00;
         taken_cnt_o         <= 8'h00;
      end else begin
         pc_word_o           <= pc_target_i;
         global_irq_enable_o <= 1'b1;
         irq_num_o           <= irq_target_i;
         if (irq_allow_i && irq_num_o != 5'h00) begin
            taken_cnt_o <= taken_cnt_o + 8'h01;
         end
      end
   end
endmodule : ivr_core_model

/* src/ivr_pkg.sv */
// Constants, types and decode helpers for the interrupt vector relocation block.
// Assumes a 12-bit word-addressed program flash and Avalon-MM byte addressing.
package ivr_pkg;

   // Register map, byte addresses
   localparam int         ADDR_W         = 4;
   localparam logic [3:0] CTRL_OFS       = 4'h0;
   localparam logic [3:0] STAT_OFS       = 4'h4;

   // Control register fields
   localparam int         CTRL_UNLOCK_B  = 0;
   localparam int         CTRL_SEL_B     = 1;
   localparam int         CTRL_EXT0_B    = 6;
   localparam int         CTRL_EXT1_B    = 7;
   localparam logic [7:0] CTRL_RST       = 8'h00;

   // Status register fields
   localparam int         STAT_SEL_B     = 0;
   localparam int         STAT_SEQ_B     = 1;
   localparam int         STAT_LOCK_B    = 2;
   localparam int         STAT_BLOCK_B   = 3;

   // Timing, in core cycles
   localparam int         UNLOCK_WIN_CYC = 4;
   localparam int         HOLD_CYC       = 1;
   localparam int         CNT_W          = 3;

   // Flash geometry, in words
   localparam int          PC_W           = 12;
   localparam logic [12:0] FLASH_WORDS    = 13'h1000;
   localparam logic [12:0] BOOT_MIN_WORDS = 13'h0080;
   localparam logic [11:0] APP_RESET_ADDR = 12'h000;
   localparam logic [1:0]  BOOT_SIZE_FUSES_MAX     = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_OPEN = 3'b010,
      ST_HOLD = 3'b100
   } ivr_state_t;

   // Boot section start word from the boot-size fuses
   function automatic logic [PC_W-1:0] ivr_boot_base_f(input logic [1:0] sz);
      logic [12:0] words;
      words = BOOT_MIN_WORDS << (BOOT_SIZE_FUSES_MAX - sz);
      return 12'(FLASH_WORDS - words);
   endfunction : ivr_boot_base_f

endpackage : ivr_pkg

/* src/ivr_top.sv */
// Interrupt vector relocation: control register, timed unlock, dispatch gating.
// Assumes an Avalon-MM master, static fuse and lock inputs, and a core that
// offers the current program word address and the pending vector number.
`timescale 1ns/100ps
module ivr_top (
   // Clock, reset, enable
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       ce_i,
   // Avalon-MM slave
   input  wire logic [ivr_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic      [31:0]                avs_readdata,
   output logic                            avs_waitrequest,
   // Fuses and lock bits, zero means programmed
   input  wire logic                       boot_reset_fuse_i,
   input  wire logic [1:0]                 boot_size_fuses_i,
   input  wire logic                       app_side_boot_lock_i,
   input  wire logic                       boot_side_boot_lock_i,
   // Core side
   input  wire logic [ivr_pkg::PC_W-1:0]   pc_word_i,
   input  wire logic                       global_irq_enable_i,
   input  wire logic [4:0]                 irq_num_i,
   output logic                            irq_allow_o,
   output logic                            irq_block_o,
   output logic      [ivr_pkg::PC_W-1:0]   reset_addr_o,
   output logic      [ivr_pkg::PC_W-1:0]   vector_addr_o,
   // Stored external interrupt enables
   output logic                            ext_irq_zero_enable_o,
   output logic                            ext_irq_one_enable_o
);
   import ivr_pkg::*;

   // Bus handshake
   logic              req;
   logic              ack_d;
   logic              ack_q;
   logic              take;
   logic              wr_ctrl;
   logic [31:0]       rdata_d;
   logic [31:0]       rdata_q;

   // Control state
   ivr_state_t        state_d;
   ivr_state_t        state_q;
   logic [CNT_W-1:0]  cnt_d;
   logic [CNT_W-1:0]  cnt_q;
   logic              sel_d;
   logic              sel_q;
   logic              ext0_d;
   logic              ext0_q;
   logic              ext1_d;
   logic              ext1_q;
   logic              wr_unlock;
   logic              wr_select;

   // Gating
   logic [PC_W-1:0]   boot_base;
   logic              in_boot;
   logic              lock_gate;
   logic              seq_block;

   // One wait cycle, then the request is taken
   assign req             = avs_read | avs_write;
   assign take            = req & ack_q & ce_i;
   assign avs_waitrequest = req & ~(ack_q & ce_i);
   assign avs_readdata    = rdata_q;
   assign wr_ctrl         = take & avs_write & (avs_address == CTRL_OFS) & avs_byteenable[0];
   assign wr_unlock       = wr_ctrl & avs_writedata[CTRL_UNLOCK_B];
   assign wr_select       = wr_ctrl & ~avs_writedata[CTRL_UNLOCK_B] & (state_q == ST_OPEN);

   always_comb begin
      ack_d   = req & ~ack_q;
      rdata_d = rdata_q;
      if (req & ~ack_q & avs_read) begin
         rdata_d = 32'h0000_0000;
         case (avs_address)
            CTRL_OFS: begin
               rdata_d[CTRL_EXT1_B]   = ext1_q;
               rdata_d[CTRL_EXT0_B]   = ext0_q;
               rdata_d[CTRL_SEL_B]    = sel_q;
               rdata_d[CTRL_UNLOCK_B] = (state_q == ST_OPEN);
            end
            STAT_OFS: begin
               rdata_d[STAT_SEL_B]   = sel_q;
               rdata_d[STAT_SEQ_B]   = seq_block;
               rdata_d[STAT_LOCK_B]  = lock_gate;
               rdata_d[STAT_BLOCK_B] = irq_block_o;
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   // Unlock sequence
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      sel_d   = sel_q;
      ext0_d  = ext0_q;
      ext1_d  = ext1_q;
      if (wr_ctrl) begin
         ext0_d = avs_writedata[CTRL_EXT0_B];
         ext1_d = avs_writedata[CTRL_EXT1_B];
      end
      case (state_q)
         ST_IDLE: begin
            if (wr_unlock) begin
               state_d = ST_OPEN;
               cnt_d   = CNT_W'(UNLOCK_WIN_CYC - 1);
            end
         end
         ST_OPEN: begin
            if (wr_unlock) begin
               state_d = ST_OPEN;
               cnt_d   = CNT_W'(UNLOCK_WIN_CYC - 1);
            end else if (wr_select) begin
               sel_d   = avs_writedata[CTRL_SEL_B];
               state_d = ST_HOLD;
               cnt_d   = CNT_W'(HOLD_CYC - 1);
            end else if (cnt_q == '0) begin
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_HOLD: begin
            if (wr_unlock) begin
               state_d = ST_OPEN;
               cnt_d   = CNT_W'(UNLOCK_WIN_CYC - 1);
            end else if (cnt_q == '0) begin
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d   = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q   <= '0;
         sel_q   <= CTRL_RST[CTRL_SEL_B];
         ext0_q  <= CTRL_RST[CTRL_EXT0_B];
         ext1_q  <= CTRL_RST[CTRL_EXT1_B];
      end else if (ce_i) begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         sel_q   <= sel_d;
         ext0_q  <= ext0_d;
         ext1_q  <= ext1_d;
      end
   end

   // Dispatch gating
   always_comb begin
      boot_base = ivr_boot_base_f(boot_size_fuses_i);
      in_boot   = (pc_word_i >= boot_base);
      seq_block = (state_q != ST_IDLE);
      lock_gate = (sel_q & ~app_side_boot_lock_i & ~in_boot)
                | (~sel_q & ~boot_side_boot_lock_i & in_boot);
   end

   assign irq_block_o = seq_block | lock_gate;
   // global flag passed through, never written
   assign irq_allow_o = global_irq_enable_i & ~irq_block_o;

   assign ext_irq_zero_enable_o = ext0_q;
   assign ext_irq_one_enable_o  = ext1_q;

   ivr_vector_map u_map (
      .core_clk_i            (core_clk_i),
      .rst_i                 (rst_i),
      .ce_i                  (ce_i),
      .vector_table_select_i (sel_q),
      .boot_reset_fuse_i     (boot_reset_fuse_i),
      .boot_size_fuses_i     (boot_size_fuses_i),
      .irq_num_i             (irq_num_i),
      .reset_addr_o          (reset_addr_o),
      .vector_addr_o         (vector_addr_o)
   );

   // Checks
   logic [CNT_W:0] open_age_q;
   logic           sel_ok_q;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         open_age_q <= '0;
         sel_ok_q   <= 1'b0;
      end else if (ce_i) begin
         open_age_q <= (state_d == ST_OPEN && !wr_unlock && state_q == ST_OPEN)
                       ? open_age_q + 1'b1 : '0;
         sel_ok_q   <= wr_select;
      end
   end

   a_open_window: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      open_age_q < (CNT_W+1)'(UNLOCK_WIN_CYC))
      else $error("unlock bit held past its window");

   a_unlock_expire: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_unlock && ce_i) ##1 (ce_i && !wr_ctrl) [*4] |=> !seq_block)
      else $error("sequence block not released after four cycles");

   a_unlock_blocks: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_unlock && ce_i) |=> irq_block_o && !irq_allow_o)
      else $error("interrupts not blocked after unlock write");

   a_select_guard: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      $changed(sel_q) |-> sel_ok_q)
      else $error("select changed outside unlock sequence");

   a_select_hold: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_select && ce_i) |=> seq_block && state_q == ST_HOLD)
      else $error("block dropped at select write");

   a_gie_kept: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (global_irq_enable_i && !irq_block_o) |-> irq_allow_o)
      else $error("global enable altered by gating");

   a_app_lock: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (sel_q && !app_side_boot_lock_i && pc_word_i < boot_base) |-> !irq_allow_o)
      else $error("interrupt allowed from application with boot vectors locked");

   a_boot_lock: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!sel_q && !boot_side_boot_lock_i && pc_word_i >= boot_base) |-> !irq_allow_o)
      else $error("interrupt allowed from boot with app vectors locked");

   a_vec_app: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && !sel_q) |=> vector_addr_o == {7'h00, $past(irq_num_i)})
      else $error("vector not at flash start");

   a_vec_boot: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && sel_q && boot_size_fuses_i == 2'h0)
      |=> vector_addr_o == 12'hc00 + {7'h00, $past(irq_num_i)})
      else $error("vector not at boot start");

   a_reset_addr: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && boot_size_fuses_i == 2'h0)
      |=> reset_addr_o == ($past(boot_reset_fuse_i) ? 12'h000 : 12'hc00))
      else $error("reset address wrong for fuse setting");

   a_ctrl_middle: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (take && avs_read && avs_address == CTRL_OFS) |-> avs_readdata[5:2] == 4'h0)
      else $error("unused control bits read nonzero");

   a_select_locked: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (state_q != ST_OPEN) |=> $stable(sel_q))
      else $error("select changed with unlock window closed");

   a_window_close: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && state_q == ST_OPEN && cnt_q == '0 && !wr_ctrl) |=> state_q == ST_IDLE)
      else $error("unlock bit not cleared at end of window");

   a_hold_release: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && state_q == ST_HOLD && !wr_unlock) |=> !seq_block)
      else $error("block held past the following instruction");

   a_block_free: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (state_q == ST_IDLE && !lock_gate) |-> !irq_block_o)
      else $error("block stuck with sequence idle");

endmodule : ivr_top

/* src/ivr_vector_map.sv */
// Registered reset address and vector fetch address generator.
// Assumes fuse inputs are static and the core samples outputs one cycle later.
`timescale 1ns/100ps
module ivr_vector_map (
   // Clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   // Placement controls
   input  wire logic                     vector_table_select_i,
   input  wire logic                     boot_reset_fuse_i,
   input  wire logic [1:0]               boot_size_fuses_i,
   input  wire logic [4:0]               irq_num_i,
   // Addresses
   output logic      [ivr_pkg::PC_W-1:0] reset_addr_o,
   output logic      [ivr_pkg::PC_W-1:0] vector_addr_o
);
   import ivr_pkg::*;

   logic [PC_W-1:0] boot_base;
   logic [PC_W-1:0] reset_addr_d;
   logic [PC_W-1:0] reset_addr_q;
   logic [PC_W-1:0] vector_addr_d;
   logic [PC_W-1:0] vector_addr_q;

   always_comb begin
      boot_base = ivr_boot_base_f(boot_size_fuses_i);
      reset_addr_d = boot_reset_fuse_i ? APP_RESET_ADDR : boot_base;
      vector_addr_d = (vector_table_select_i ? boot_base : APP_RESET_ADDR)
                      + {{(PC_W-5){1'b0}}, irq_num_i};
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         reset_addr_q  <= APP_RESET_ADDR;
         vector_addr_q <= APP_RESET_ADDR;
      end else if (ce_i) begin
         reset_addr_q  <= reset_addr_d;
         vector_addr_q <= vector_addr_d;
      end
   end

   assign reset_addr_o  = reset_addr_q;
   assign vector_addr_o = vector_addr_q;

endmodule : ivr_vector_map
